/* File: logic/sld_defs.vh */
`ifndef SLD_DEFS_VH
`define SLD_DEFS_VH

// Data path width: one stage, latch and sink output per bit
`define SLD_WIDTH 8
`define SLD_LAST 7

// Reset values
`define SLD_SHIFT_RST 8'h00
`define SLD_LATCH_RST 8'h00
`define SLD_SINK_OFF 8'h00

// Synchroniser reset levels (blanking pin idles high, others low)
`define SLD_SYNC_LOW 3'h0
`define SLD_SYNC_HIGH 3'h7

// Single-bit levels for filtered pins and registered outputs
`define SLD_LVL_LOW 1'h0
`define SLD_LVL_HIGH 1'h1

// Host-side timing figures, in ns, and their least cycle counts
`define SLD_CLK_PERIOD_NS 100
`define SLD_CLK_TO_STROBE_NS 100
`define SLD_STROBE_WIDTH_NS 100
`define SLD_BLANK_WIDTH_NS 4500
`define SLD_CLK_TO_STROBE_CYC \
  ((`SLD_CLK_TO_STROBE_NS + `SLD_CLK_PERIOD_NS - 1) / `SLD_CLK_PERIOD_NS)
`define SLD_STROBE_WIDTH_CYC \
  ((`SLD_STROBE_WIDTH_NS + `SLD_CLK_PERIOD_NS - 1) / `SLD_CLK_PERIOD_NS)
`define SLD_BLANK_WIDTH_CYC \
  ((`SLD_BLANK_WIDTH_NS + `SLD_CLK_PERIOD_NS - 1) / `SLD_CLK_PERIOD_NS)

`endif

/* File: logic/sld_driver.v */
`timescale 1ns/1ps
`default_nettype none
`include "sld_defs.vh"

module sld_driver (
  input wire clock,
  input wire rst_n,
  input wire serial_clk,
  input wire serial_in,
  input wire strobe_load,
  input wire drive_blank_n,
  input wire half_current_select,
  output reg [`SLD_LAST:0] sink_drive_ff,
  output reg half_current_ff,
  output reg cascade_out_rise_ff,
  output reg cascade_out_fall_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers, filtered levels and working registers
  reg [2:0] sclk_sync_ff;
  reg [2:0] sdat_sync_ff;
  reg [2:0] strb_sync_ff;
  reg [2:0] blnk_sync_ff;
  reg [2:0] half_sync_ff;
  reg sclk_lvl_ff;
  reg strb_lvl_ff;
  reg blnk_lvl_ff;
  reg half_lvl_ff;
  reg [`SLD_LAST:0] shift_ff;
  reg [`SLD_LAST:0] latch_ff;
  reg nxt_sclk_lvl;
  reg nxt_strb_lvl;
  reg nxt_blnk_lvl;
  reg nxt_half_lvl;
  reg nxt_sclk_rise;
  reg nxt_sclk_fall;
  reg [`SLD_LAST:0] nxt_shift;
  reg [`SLD_LAST:0] nxt_latch;
  reg [`SLD_LAST:0] nxt_sink_drive;
  reg nxt_half_current;
  reg nxt_cascade_out_rise;
  reg nxt_cascade_out_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Level moves only once stages 1 and 2 agree; a one-clock glitch
  // never reaches both, so it is dropped
  function filt;
    input [2:0] sync;
    input cur;
    begin
      filt = (sync[1] == sync[2]) ? sync[2] : cur;
    end
  endfunction

  // Accepted level steps to the given value on this edge
  function stepped;
    input nxt_lvl;
    input cur_lvl;
    input to_lvl;
    begin
      stepped = (nxt_lvl != cur_lvl) && (nxt_lvl == to_lvl);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Three-flop pin synchronisers; stage 0 feeds only stage 1
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_ff <= `SLD_SYNC_LOW;
    end else begin
      sclk_sync_ff <= {sclk_sync_ff[1:0], serial_clk};
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sdat_sync_ff <= `SLD_SYNC_LOW;
    end else begin
      sdat_sync_ff <= {sdat_sync_ff[1:0], serial_in};
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strb_sync_ff <= `SLD_SYNC_LOW;
    end else begin
      strb_sync_ff <= {strb_sync_ff[1:0], strobe_load};
    end
  end

  // Blanking starts high, so sink outputs stay off until a host releases it
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      blnk_sync_ff <= `SLD_SYNC_HIGH;
    end else begin
      blnk_sync_ff <= {blnk_sync_ff[1:0], drive_blank_n};
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      half_sync_ff <= `SLD_SYNC_LOW;
    end else begin
      half_sync_ff <= {half_sync_ff[1:0], half_current_select};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Filtered pin levels
  always @* begin
    nxt_sclk_lvl = filt(sclk_sync_ff, sclk_lvl_ff);
    nxt_strb_lvl = filt(strb_sync_ff, strb_lvl_ff);
    nxt_blnk_lvl = filt(blnk_sync_ff, blnk_lvl_ff);
    nxt_half_lvl = filt(half_sync_ff, half_lvl_ff);
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclk_lvl_ff <= `SLD_LVL_LOW;
      strb_lvl_ff <= `SLD_LVL_LOW;
      blnk_lvl_ff <= `SLD_LVL_HIGH;
      half_lvl_ff <= `SLD_LVL_LOW;
    end else begin
      sclk_lvl_ff <= nxt_sclk_lvl;
      strb_lvl_ff <= nxt_strb_lvl;
      blnk_lvl_ff <= nxt_blnk_lvl;
      half_lvl_ff <= nxt_half_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift register and latches
  always @* begin
    nxt_sclk_rise = stepped(nxt_sclk_lvl, sclk_lvl_ff, `SLD_LVL_HIGH);
    nxt_sclk_fall = stepped(nxt_sclk_lvl, sclk_lvl_ff, `SLD_LVL_LOW);
  end

  always @* begin
    nxt_shift = shift_ff;
    if (nxt_sclk_rise) begin
      // Data path delayed like the clock path, so pin setup still holds
      nxt_shift = {shift_ff[`SLD_LAST-1:0], sdat_sync_ff[2]};
    end
  end

  always @* begin
    nxt_latch = latch_ff;
    // Transparent: takes the shift value of this same edge
    if (nxt_strb_lvl) begin
      nxt_latch = nxt_shift;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shift_ff <= `SLD_SHIFT_RST;
      latch_ff <= `SLD_LATCH_RST;
    end else begin
      shift_ff <= nxt_shift;
      latch_ff <= nxt_latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop
  always @* begin
    // Blanking gates the sink outputs only; the latches are untouched
    if (blnk_lvl_ff) begin
      nxt_sink_drive = `SLD_SINK_OFF;
    end else begin
      nxt_sink_drive = latch_ff;
    end
  end

  always @* begin
    nxt_half_current = half_lvl_ff;
  end

  always @* begin
    nxt_cascade_out_rise = cascade_out_rise_ff;
    if (nxt_sclk_rise) begin
      nxt_cascade_out_rise = nxt_shift[`SLD_LAST];
    end
  end

  always @* begin
    nxt_cascade_out_fall = cascade_out_fall_ff;
    // The shifter holds still on a fall, so its last stage is current
    if (nxt_sclk_fall) begin
      nxt_cascade_out_fall = shift_ff[`SLD_LAST];
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sink_drive_ff <= `SLD_SINK_OFF;
      half_current_ff <= `SLD_LVL_LOW;
    end else begin
      sink_drive_ff <= nxt_sink_drive;
      half_current_ff <= nxt_half_current;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cascade_out_rise_ff <= `SLD_LVL_LOW;
      cascade_out_fall_ff <= `SLD_LVL_LOW;
    end else begin
      cascade_out_rise_ff <= nxt_cascade_out_rise;
      cascade_out_fall_ff <= nxt_cascade_out_fall;
    end
  end

endmodule // sld_driver

`default_nettype wire

/* File: test/sld_driver_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module sld_driver_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic strobe_load,
  input wire logic drive_blank_n,
  input wire logic half_current_select,
  input wire logic [7:0] sink_drive_ff,
  input wire logic half_current_ff,
  input wire logic cascade_out_rise_ff,
  input wire logic cascade_out_fall_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_blank; drive_blank_n [*6] |-> sink_drive_ff == 8'h00; endproperty
  a_blank: assert property (p_blank) else $error("sink on");
  property p_half; $stable(half_current_select) [*6] |->
    half_current_ff == half_current_select; endproperty
  a_half: assert property (p_half) else $error("current level");
  // Pin filter puts the action four edges after the pin change
  property p_rise; $changed(cascade_out_rise_ff) |->
    $past(serial_clk, 4) && !$past(serial_clk, 5); endproperty
  a_rise: assert property (p_rise) else $error("rise out moved");
  property p_fall; $changed(cascade_out_fall_ff) |->
    !$past(serial_clk, 4) && $past(serial_clk, 5); endproperty
  a_fall: assert property (p_fall) else $error("fall out moved");
  property p_copy; $changed(cascade_out_fall_ff) |->
    cascade_out_fall_ff == cascade_out_rise_ff; endproperty
  a_copy: assert property (p_copy) else $error("fall copy");
  property p_quiet; !serial_clk [*6] |-> $stable(cascade_out_rise_ff);
  endproperty
  a_quiet: assert property (p_quiet) else $error("no edge");
  property p_hold; (!strobe_load && !drive_blank_n) [*7] |->
    $stable(sink_drive_ff); endproperty
  a_hold: assert property (p_hold) else $error("latch moved");
  property p_lit; $changed(sink_drive_ff) && sink_drive_ff != 8'h00 |->
    !$past(drive_blank_n, 5); endproperty
  a_lit: assert property (p_lit) else $error("lit while blanked");
endmodule // sld_driver_checker
`default_nettype wire

/* File: test/sld_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sld_host (
  input wire logic clock,
  input wire logic go,
  input wire logic [7:0] data,
  output logic sck = 1'h0,
  output logic sdi = 1'h0,
  output logic busy = 1'h0
);
  logic [5:0] cnt_ff = 6'h00;
  // MSB first; clock high in the late half of each bit for setup
  always @(posedge clock) begin
    if (busy) begin
      sdi <= data[~cnt_ff[5:3]];
      sck <= cnt_ff[2];
      cnt_ff <= cnt_ff + 6'h01;
      busy <= (cnt_ff != 6'h3F);
    end else begin
      sck <= 1'h0;
      cnt_ff <= 6'h00;
      busy <= go;
    end
  end
endmodule // sld_host
`default_nettype wire

/* File: test/test_serial_latched_sink_driver.sv */
`timescale 1ns/1ps
`default_nettype none
module test_serial_latched_sink_driver;
  logic clock = 1'h0, rst_n = 1'h0, go = 1'h0, serial_clk, serial_in, busy;
  logic strobe_load = 1'h0, drive_blank_n = 1'h1, half_current_select = 1'h0;
  logic [7:0] data = 8'h00, a, b, sink_drive_ff;
  logic half_current_ff, cascade_out_rise_ff, cascade_out_fall_ff;
  logic [31:0] s = 32'h62;
  logic [10:0] q[$];
  int n_errors = 0, n_tests = 0;
  event look;
  always #50 clock = ~clock;
  sld_host i_host (.clock, .go, .data, .sck(serial_clk), .sdi(serial_in),
    .busy);
  sld_driver i_dut (.clock, .rst_n, .serial_clk, .serial_in, .strobe_load,
    .drive_blank_n, .half_current_select, .sink_drive_ff, .half_current_ff,
    .cascade_out_rise_ff, .cascade_out_fall_ff);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic complete_run;
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic send(input logic [7:0] v);
    int k;
    data = v;
    go = 1'h1;
    tick(2);
    go = 1'h0;
    for (k = 0; k < 200 && busy === 1'h1; k++) tick(1);
    if (k == 200) begin
      n_errors++;
      complete_run;
    end
    tick(6);
  endtask
  task automatic compare(input logic [10:0] e, input logic [10:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %h not %h", $time, g, e);
    end
  endtask
  task automatic note(input logic [10:0] e);
    q.push_back(e);
    -> look;
  endtask
  always @(look) compare(q.pop_front(), {half_current_ff, cascade_out_fall_ff,
    cascade_out_rise_ff, sink_drive_ff});
  initial begin
    tick(4);
    rst_n = 1'h1;
    tick(2);
    for (int i = 0; i < 6; i++) begin
      half_current_select = i[0];
      s = xs(s);
      a = s[7:0];
      s = xs(s);
      b = s[7:0];
      send(a);
      strobe_load = 1'h1;
      tick(3);
      strobe_load = i[1];
      send(b);
      strobe_load = 1'h0;
      tick(6);
      drive_blank_n = 1'h0;
      tick(48);
      note({half_current_select, b[7], b[7], i[1] ? b : a});
      drive_blank_n = 1'h1;
      tick(48);
      note({half_current_select, b[7], b[7], 8'h00});
    end
    // Let the watcher take the last note before the verdict
    tick(2);
    complete_run;
  end
endmodule // test_serial_latched_sink_driver
bind sld_driver sld_driver_checker i_chk (.clock, .rst_n, .serial_clk,
  .strobe_load, .drive_blank_n, .half_current_select, .sink_drive_ff,
  .half_current_ff, .cascade_out_rise_ff, .cascade_out_fall_ff);
`default_nettype wire
